// ---- core/pmt_consts.svh ----
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define PMT_OFS_CTRL 12'h000
`define PMT_OFS_STATUS 12'h004
`define PMT_OFS_VIOL 12'h008
`define PMT_OFS_FENCE 12'h00c
`define PMT_MAP_WIN 3'h1

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define PMT_CTL_EN 0
`define PMT_CTL_USER 1
`define PMT_CTL_PROT 2
`define PMT_CTL_RESET 3'h0

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define PMT_ST_LAST_EN 15
`define PMT_ST_LAST_USER 14
`define PMT_ST_EN 13
`define PMT_ST_USER 12
`define PMT_ST_PROT 11
`define PMT_ST_FMODE 10

// ---------------------------------------------------------------
// Violation register fields
// ---------------------------------------------------------------
`define PMT_VI_RD 15
`define PMT_VI_WR 14
`define PMT_VI_BASE 13
`define PMT_VI_PRIV 12
`define PMT_VI_EN 6
`define PMT_VI_USER 5

// ---------------------------------------------------------------
// Map entry and data word layout
// ---------------------------------------------------------------
`define PMT_ENT_RP 11
`define PMT_ENT_WP 10
`define PMT_WORD_RP 15
`define PMT_WORD_WP 14
`define PMT_PAGES 32
`define PMT_MAPS 4
`define PMT_ENTRIES 128
`define PMT_ENT_RESET 12'h000
`define PMT_FENCE_RESET 11'h000

// ---------------------------------------------------------------
// Map identifiers
// ---------------------------------------------------------------
`define PMT_MAP_SYS 2'h0
`define PMT_MAP_USER 2'h1
`define PMT_MAP_PORT 1'h1

`endif

// ---- core/pmt_pkg.sv ----
package pmt_pkg;

   // Access from the processor side
   typedef struct packed
   {
      logic req;
      logic we;
      logic port_ctrl;
      logic port_ctrl_ch;
      logic [14:0] adr;
   } pmt_acc_t;

   // Access toward physical memory, with violation pulses
   typedef struct packed
   {
      logic req;
      logic we;
      logic [19:0] adr;
      logic rd_viol;
      logic wr_viol;
   } pmt_mem_t;

   typedef struct packed
   {
      logic flag;
   } pmt_flag_state_t;

   typedef struct packed
   {
      logic ack;
      logic [31:0] dat;
      logic en;
      logic user;
      logic prot;
      logic last_en;
      logic last_user;
      logic [10:0] fence;
      logic [127:0][11:0] map;
      pmt_mem_t mem;
      logic [6:0] ctx;
   } pmt_state_t;

endpackage

// ---- core/pmt_flag.sv ----
`timescale 1ns/1ns
`include "pmt_consts.svh"

module pmt_flag
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);
   import pmt_pkg::*;

   pmt_flag_state_t q, d;

   // ---------------------------------------------------------------
   // Sticky flag, set beats clear
   // ---------------------------------------------------------------
   always_comb
   begin
      d = q;
      if (set_i)
      begin
         d.flag = 1'b1;
      end
      else if (clr_i)
      begin
         d.flag = 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign flag_o = q.flag;

   set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      set_i |=> flag_o)
      else $error("flag lost on set");

endmodule

// ---- core/pmt_xlate.sv ----
`timescale 1ns/1ns
`include "pmt_consts.svh"

module pmt_xlate
(
   input wire logic en_i,
   input wire logic port_ctrl_i,
   input wire logic [10:0] fence_i,
   input wire logic [14:0] adr_i,
   input wire logic [11:0] entry_i,
   output logic [19:0] phys_o,
   output logic rd_prot_o,
   output logic wr_prot_o,
   output logic shared_o
);
   import pmt_pkg::*;

   logic page0;
   logic in_region;

   // ---------------------------------------------------------------
   // Base page split and address build
   // ---------------------------------------------------------------
   always_comb
   begin
      page0 = (adr_i[14:10] == 5'h00);
      // Low region below fence, or fence up to top of page zero
      in_region = fence_i[`PMT_ST_FMODE] ? (adr_i[9:0] < fence_i[9:0])
                                         : (adr_i[9:0] >= fence_i[9:0]);
      shared_o = en_i && page0 && !port_ctrl_i && !in_region;
      if (!en_i || shared_o)
      begin
         phys_o = {5'h00, adr_i};
         rd_prot_o = 1'b0;
         wr_prot_o = 1'b0;
      end
      else
      begin
         phys_o = {entry_i[9:0], adr_i[9:0]};
         rd_prot_o = entry_i[`PMT_ENT_RP];
         wr_prot_o = entry_i[`PMT_ENT_WP];
      end
   end

endmodule

// ---- core/pmt_top.sv ----
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`include "pmt_consts.svh"

// Overview of operation
// - Logical space is 32 pages of 1024 words
// - Upper 5 bits page, lower 10 offset
// - Page number selects one of 32 entries
// - Physical page joined with offset, 20 bits
// - Four maps, entries writable any time
// - Entry bit 11 marks page read-protected
// - Entry bit 10 marks page write-protected
// - Data bits 13 to 10 ignored
// - Status 15 shows enable at last interrupt
// - Status 14 shows user map at interrupt
// - Status 13 shows mapping enabled now
// - Status 12 shows user map now
// - Status 11 shows protected mode now
// - Status reports base page fence
// - Fence in 9:0, bit 10 picks region
// - Protected access flags violation, is suppressed
// - Violation bits 15 to 12 flag causes
// - Port controller accesses never checked

module pmt_top
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire pmt_pkg::pmt_acc_t acc_i,
   input wire logic int_taken_i,
   input wire logic priv_viol_i,
   output pmt_pkg::pmt_mem_t mem_o
);
   import pmt_pkg::*;

   pmt_state_t q, d;
   logic bus_go;
   logic bus_wr;
   logic map_hit;
   logic [6:0] map_idx;
   logic [6:0] acc_idx;
   logic [1:0] acc_map;
   logic [11:0] acc_entry;
   logic [19:0] phys;
   logic rd_prot;
   logic wr_prot;
   logic shared;
   logic chk;
   logic rd_v;
   logic wr_v;
   logic base_v;
   logic any_v;
   logic viol_clr;
   logic [3:0] viol_flags;
   logic [15:0] status_word;

   // ---------------------------------------------------------------
   // Map lookup for the access in flight
   // ---------------------------------------------------------------
   always_comb
   begin
      if (acc_i.port_ctrl)
      begin
         acc_map = {`PMT_MAP_PORT, acc_i.port_ctrl_ch};
      end
      else
      begin
         acc_map = q.user ? `PMT_MAP_USER : `PMT_MAP_SYS;
      end
      acc_idx = {acc_map, acc_i.adr[14:10]};
      acc_entry = q.map[acc_idx];
   end

   pmt_xlate u_xlate
   (
      .en_i(q.en),
      .port_ctrl_i(acc_i.port_ctrl),
      .fence_i(q.fence),
      .adr_i(acc_i.adr),
      .entry_i(acc_entry),
      .phys_o(phys),
      .rd_prot_o(rd_prot),
      .wr_prot_o(wr_prot),
      .shared_o(shared)
   );

   // ---------------------------------------------------------------
   // Protection checks
   // ---------------------------------------------------------------
   always_comb
   begin
      chk = q.en && !acc_i.port_ctrl;
      rd_v = acc_i.req && !acc_i.we && chk && rd_prot;
      wr_v = acc_i.req && acc_i.we && chk && wr_prot;
      // Writes into shared base page trip in protected mode
      base_v = acc_i.req && acc_i.we && chk && q.prot && shared;
      any_v = rd_v || wr_v || base_v;
   end

   // ---------------------------------------------------------------
   // Bus decode and read data
   // ---------------------------------------------------------------
   always_comb
   begin
      bus_go = wb_cyc_i && wb_stb_i && !q.ack;
      bus_wr = bus_go && wb_we_i && (wb_sel_i[1:0] == 2'h3);
      map_hit = (wb_adr_i[11:9] == `PMT_MAP_WIN);
      map_idx = wb_adr_i[8:2];
      viol_clr = bus_wr && (wb_adr_i == `PMT_OFS_VIOL);
      status_word = {q.last_en, q.last_user, q.en, q.user, q.prot,
                     q.fence};
   end

   pmt_flag u_rd_flag
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(rd_v),
      .clr_i(viol_clr && wb_dat_i[`PMT_VI_RD]),
      .flag_o(viol_flags[3])
   );

   pmt_flag u_wr_flag
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(wr_v),
      .clr_i(viol_clr && wb_dat_i[`PMT_VI_WR]),
      .flag_o(viol_flags[2])
   );

   pmt_flag u_base_flag
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(base_v),
      .clr_i(viol_clr && wb_dat_i[`PMT_VI_BASE]),
      .flag_o(viol_flags[1])
   );

   pmt_flag u_priv_flag
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(priv_viol_i),
      .clr_i(viol_clr && wb_dat_i[`PMT_VI_PRIV]),
      .flag_o(viol_flags[0])
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.ack = bus_go;
      d.dat = 32'h0000_0000;
      if (bus_go && !wb_we_i)
      begin
         if (map_hit)
         begin
            // Protect bits move to 15 and 14, 13 to 10 read zero
            d.dat[15:0] = {q.map[map_idx][`PMT_ENT_RP], q.map[map_idx][`PMT_ENT_WP],
                           4'h0, q.map[map_idx][9:0]};
         end
         else
         begin
            case (wb_adr_i)
               `PMT_OFS_CTRL: d.dat[2:0] = {q.prot, q.user, q.en};
               `PMT_OFS_STATUS: d.dat[15:0] = status_word;
               `PMT_OFS_VIOL: d.dat[15:0] = {viol_flags, 5'h00, q.ctx};
               `PMT_OFS_FENCE: d.dat[10:0] = q.fence;
               default: d.dat = 32'h0000_0000;
            endcase
         end
      end
      if (bus_wr)
      begin
         if (map_hit)
         begin
            d.map[map_idx] = {wb_dat_i[`PMT_WORD_RP], wb_dat_i[`PMT_WORD_WP],
                              wb_dat_i[9:0]};
         end
         else
         begin
            case (wb_adr_i)
               `PMT_OFS_CTRL:
               begin
                  d.en = wb_dat_i[`PMT_CTL_EN];
                  d.user = wb_dat_i[`PMT_CTL_USER];
                  d.prot = wb_dat_i[`PMT_CTL_PROT];
               end
               `PMT_OFS_FENCE: d.fence = wb_dat_i[10:0];
               default: d.fence = q.fence;
            endcase
         end
      end
      if (int_taken_i)
      begin
         d.last_en = q.en;
         d.last_user = q.user;
      end
      d.mem.req = acc_i.req && !any_v;
      d.mem.we = acc_i.we && acc_i.req;
      d.mem.adr = phys;
      d.mem.rd_viol = rd_v;
      d.mem.wr_viol = wr_v || base_v;
      if (any_v)
      begin
         d.ctx = {q.en, q.user, acc_i.adr[14:10]};
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q.ack <= 1'b0;
         q.dat <= 32'h0000_0000;
         {q.prot, q.user, q.en} <= `PMT_CTL_RESET;
         q.last_en <= 1'b0;
         q.last_user <= 1'b0;
         q.fence <= `PMT_FENCE_RESET;
         q.map <= '0;
         q.mem <= '0;
         q.ctx <= 7'h00;
      end
      else
      begin
         q <= d;
      end
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.dat;
   assign mem_o = q.mem;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after strobe");
   offset_keep_a: assert property (acc_i.req && q.en && acc_i.adr[14:10] != 5'h00
      |=> mem_o.adr[9:0] == $past(acc_i.adr[9:0]))
      else $error("offset not kept");
   pass_thru_a: assert property (acc_i.req && !q.en
      |=> mem_o.adr == {5'h00, $past(acc_i.adr)} && !mem_o.rd_viol && !mem_o.wr_viol)
      else $error("disabled path not identity");
   rd_suppress_a: assert property (mem_o.rd_viol |-> !mem_o.req && viol_flags[3])
      else $error("read violation not suppressed");
   wr_suppress_a: assert property (mem_o.wr_viol |-> !mem_o.req && mem_o.we)
      else $error("write violation not suppressed");
   port_exempt_a: assert property (acc_i.req && acc_i.port_ctrl
      |=> mem_o.req && !mem_o.rd_viol && !mem_o.wr_viol)
      else $error("port controller access checked");
   irq_capture_a: assert property (int_taken_i && !bus_wr
      |=> status_word[`PMT_ST_LAST_EN] == status_word[`PMT_ST_EN]
          && status_word[`PMT_ST_LAST_USER] == status_word[`PMT_ST_USER])
      else $error("interrupt state not captured");
   ctrl_status_a: assert property (bus_wr && wb_adr_i == `PMT_OFS_CTRL
      |=> status_word[`PMT_ST_EN] == $past(wb_dat_i[`PMT_CTL_EN])
          && status_word[`PMT_ST_PROT] == $past(wb_dat_i[`PMT_CTL_PROT]))
      else $error("status does not follow control");

   // ---------------------------------------------------------------
   // Translation and protection checks
   // ---------------------------------------------------------------
   logic [11:0] exp_entry;
   assign exp_entry = q.map[{acc_i.port_ctrl, (acc_i.port_ctrl ? acc_i.port_ctrl_ch : q.user),
                             acc_i.adr[14:10]}];

   page_join_a: assert property (acc_i.req && q.en && !shared
      |=> mem_o.adr[19:10] == $past(exp_entry[9:0]))
      else $error("physical page not from selected entry");
   rd_protect_a: assert property (acc_i.req && !acc_i.we && chk && !shared
      && exp_entry[`PMT_ENT_RP] |=> mem_o.rd_viol && !mem_o.req)
      else $error("read-protected page not refused");
   wr_protect_a: assert property (acc_i.req && acc_i.we && chk && !shared
      && exp_entry[`PMT_ENT_WP] |=> mem_o.wr_viol && !mem_o.req)
      else $error("write-protected page not refused");
   base_page_a: assert property (acc_i.req && acc_i.we && chk && q.prot && shared
      |=> mem_o.wr_viol && !mem_o.req && viol_flags[1])
      else $error("shared base page write not flagged");
   viol_ctx_a: assert property (rd_v || wr_v || base_v
      |=> q.ctx == {$past(q.en), $past(q.user), $past(acc_i.adr[14:10])})
      else $error("violation context not logged");
   map_write_a: assert property (bus_wr && map_hit
      |=> q.map[$past(map_idx)] == {$past(wb_dat_i[15:14]), $past(wb_dat_i[9:0])})
      else $error("map entry not stored");

endmodule

// ---- tb/pmt_mem_model.sv ----
`timescale 1ns/1ns

module pmt_mem_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pmt_pkg::pmt_mem_t mem_i,
   output logic [15:0] n_wr_o
);
   import pmt_pkg::*;

   // Counts writes that really reach memory
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         n_wr_o <= 16'h0000;
      else if (mem_i.req && mem_i.we)
         n_wr_o <= n_wr_o + 16'h0001;
   end
endmodule

// ---- tb/pmt_top_test.sv ----
`timescale 1ns/1ns

module pmt_top_test;
   import pmt_pkg::*;

   typedef struct packed {logic [11:0] adr; logic [15:0] wd; logic [15:0] rd;} pmt_row_t;

   logic clk_i, rst_i, cyc, stb, we, ack, int_taken, priv_viol;
   logic [11:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, dat_o;
   pmt_acc_t acc;
   pmt_mem_t mem;
   logic [15:0] n_wr, n_wr0;
   int n_mismatch = 0;
   int checks_done = 0;

   // ---------------------------------------------
   // Write value, expected read-back
   // ---------------------------------------------
   pmt_row_t rows [11] = '{
      '{12'h20c, 16'hfc55, 16'hc055},
      '{12'h2fc, 16'h03ff, 16'h03ff},
      '{12'h284, 16'h4055, 16'h4055},
      '{12'h288, 16'h80aa, 16'h80aa},
      '{12'h300, 16'h4001, 16'h4001},
      '{12'h380, 16'h0002, 16'h0002},
      '{12'h200, 16'h0123, 16'h0123},
      '{12'h00c, 16'h0500, 16'h0500},
      '{12'h010, 16'h1234, 16'h0000},
      '{12'h000, 16'h0007, 16'h0007},
      '{12'h004, 16'hffff, 16'h3d00}
   };

   pmt_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .acc_i(acc), .int_taken_i(int_taken), .priv_viol_i(priv_viol),
      .mem_o(mem));

   pmt_mem_model mem_model (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem), .n_wr_o(n_wr));

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic complete_run();
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0000, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0000);
      check_word(rdat, {16'h0000, e});
   endtask

   // Port is {controller, channel}; flags are {req, read violation, write violation}
   task automatic access(input logic w, input logic [1:0] dc, input logic [14:0] a,
      input logic [19:0] ea, input logic [2:0] f);
      @(posedge clk_i);
      acc <= '{1'b1, w, dc[1], dc[0], a};
      @(posedge clk_i);
      acc <= '0;
      #1;
      checks_done++;
      if ({mem.req, mem.rd_viol, mem.wr_viol} !== f || (f[2] && mem.adr !== ea))
      begin
         n_mismatch++;
         $display("wrong value at %0t: memory access %h", $time, mem);
      end
   endtask

   task automatic pulse(input logic irq);
      @(posedge clk_i);
      int_taken <= irq;
      priv_viol <= !irq;
      @(posedge clk_i);
      int_taken <= 1'b0;
      priv_viol <= 1'b0;
   endtask

   initial
   begin
      #20000;
      n_mismatch++;
      complete_run();
   end

   initial
   begin
      {cyc, stb, we, int_taken, priv_viol} = 5'h00;
      rst_i = 1'b1;
      adr = 12'h000;
      wdat = 32'h00000000;
      sel = 4'hf;
      acc = '0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i])
      begin
         bus(1'b1, rows[i].adr, rows[i].wd);
         rd_chk(rows[i].adr, rows[i].rd);
      end
      // ------------------------------------------
      // Translation and protection, user map and port controller maps
      // ------------------------------------------
      access(1'b0, 2'h0, {5'd31, 10'h02a}, 20'hffc2a, 3'b100);
      n_wr0 = n_wr;
      access(1'b1, 2'h0, {5'd1, 10'h011}, 20'h00000, 3'b001);
      access(1'b0, 2'h0, {5'd2, 10'h000}, 20'h00000, 3'b010);
      check_word({16'h0000, n_wr}, {16'h0000, n_wr0});
      access(1'b0, 2'h0, {5'd1, 10'h011}, 20'h15411, 3'b100);
      bus(1'b0, 12'h008, 16'h0000);
      check_word(rdat & 32'h0000f000, 32'h0000c000);
      bus(1'b1, 12'h008, 16'hf000);
      bus(1'b0, 12'h008, 16'h0000);
      check_word(rdat & 32'h0000f000, 32'h00000000);
      access(1'b1, 2'h2, {5'd0, 10'h3ff}, 20'h007ff, 3'b100);
      access(1'b1, 2'h3, {5'd0, 10'h3ff}, 20'h00bff, 3'b100);
      // ------------------------------------------
      // Base page fence, system map
      // ------------------------------------------
      bus(1'b1, 12'h000, 16'h0005);
      access(1'b0, 2'h0, {5'd0, 10'h050}, 20'h48c50, 3'b100);
      access(1'b0, 2'h0, {5'd0, 10'h200}, 20'h00200, 3'b100);
      access(1'b1, 2'h0, {5'd0, 10'h200}, 20'h00000, 3'b001);
      bus(1'b1, 12'h00c, 16'h0100);
      access(1'b0, 2'h0, {5'd0, 10'h050}, 20'h00050, 3'b100);
      access(1'b0, 2'h0, {5'd0, 10'h200}, 20'h48e00, 3'b100);
      // ------------------------------------------
      // Interrupt capture and pass-through
      // ------------------------------------------
      bus(1'b1, 12'h000, 16'h0003);
      pulse(1'b1);
      bus(1'b1, 12'h000, 16'h0000);
      rd_chk(12'h004, 16'hc100);
      access(1'b0, 2'h0, 15'h7abc, 20'h07abc, 3'b100);
      pulse(1'b0);
      bus(1'b0, 12'h008, 16'h0000);
      check_word(rdat, 32'h00003040);
      // ------------------------------------------
      // Reset in mid-run
      // ------------------------------------------
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(12'h20c, 16'h0000);
      rd_chk(12'h004, 16'h0000);
      complete_run();
   end
endmodule
